// ### rtl/touch_gesture_reader.sv
// Purpose: Fetch touch reports from a panel controller and present them.
// Assumes: Panel request line is active low and asynchronous.
// Notes: Results change only when a full read completes, with ready.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (RULE_01) Clocked from one reference clock
// (RULE_02) System reset starts core known
// (RULE_03) Trigger wired to panel interrupt
// (RULE_04) Core drives serial clock as master
// (RULE_05) Data line driven, released for replies
// (RULE_06) Read panel, decode coordinates and gesture
// (RULE_07) Ready rises only with valid results
// (RULE_08) First point: 10-bit x, 9-bit y
// (RULE_09) Second point: 10-bit x, 9-bit y
// (RULE_10) Point count 2 bits, zero to two
// (RULE_11) Gesture reported as 8-bit code
// (RULE_12) One-point gesture codes fixed
// (RULE_13) Two-point gesture codes fixed
// (RULE_14) Host treats unknown code as touch
// (RULE_15) Low trigger requests a fetch
// (RULE_16) Reset drops ready, idles lines, aborts
// (RULE_17) Results stable until next read ends
module touch_gesture_reader #(
  parameter logic [6:0] PANEL_ADDR = 7'h38, // Arbitrary default address
  parameter logic [7:0] REPORT_REG = 8'h00,
  parameter int QUARTER = touch_pkg::QUARTER_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic touch_request_in,
  output logic result_valid_out,
  output logic [touch_pkg::X_W-1:0] first_point_x,
  output logic [touch_pkg::Y_W-1:0] first_point_y,
  output logic [touch_pkg::X_W-1:0] second_point_x,
  output logic [touch_pkg::Y_W-1:0] second_point_y,
  output logic [touch_pkg::CNT_W-1:0] point_count,
  output logic [touch_pkg::GEST_W-1:0] gesture_code,
  output logic panel_serial_clk,
  output logic panel_serial_data_out,
  output logic panel_serial_data_oe,
  input wire logic panel_serial_data_in
);
  typedef enum {
    ST_IDLE, ST_START, ST_ADDR_W, ST_REG, ST_RESTART, ST_ADDR_R,
    ST_READ, ST_STOP, ST_PUBLISH
  } fetch_state_t;

  localparam int IW = $clog2(touch_pkg::READ_BYTES);
  localparam logic [IW-1:0] LAST_IDX = IW'(touch_pkg::READ_BYTES - 1);

  fetch_state_t state;
  touch_pkg::touch_report_t report;
  touch_pkg::i2c_cmd_t cmd;
  logic [7:0] rx_buf [touch_pkg::READ_BYTES];
  logic [IW-1:0] idx;
  logic req_m;
  logic req_s;
  logic waiting;
  logic abort;
  logic cmd_valid;
  logic eng_busy;
  logic eng_done;
  logic eng_nack;
  logic [7:0] eng_data;

  // Ten-bit coordinate from high and low bytes
  function automatic logic [touch_pkg::X_W-1:0] coord_x(
    input logic [7:0] hi, input logic [7:0] lo);
    coord_x = {hi[1:0], lo};
  endfunction

  // Nine-bit coordinate from high and low bytes
  function automatic logic [touch_pkg::Y_W-1:0] coord_y(
    input logic [7:0] hi, input logic [7:0] lo);
    coord_y = {hi[0], lo};
  endfunction

  // Two-stage synchroniser on the panel request pin
  always_ff @(posedge core_clk) begin
    req_m <= touch_request_in;
    req_s <= req_m;
  end

  // Command for the current state
  always_comb begin
    cmd.op = touch_pkg::OP_WRITE;
    cmd.data = touch_pkg::IDLE_BYTE;
    cmd.last = 1'b0;
    unique case (state)
      ST_START, ST_RESTART: cmd.op = touch_pkg::OP_START;
      ST_STOP: cmd.op = touch_pkg::OP_STOP;
      ST_ADDR_W: cmd.data = {PANEL_ADDR, touch_pkg::RW_WRITE};
      ST_REG: cmd.data = REPORT_REG;
      ST_ADDR_R: cmd.data = {PANEL_ADDR, touch_pkg::RW_READ};
      ST_READ: begin
        cmd.op = touch_pkg::OP_READ;
        cmd.last = (idx == LAST_IDX);
      end
      default: ;
    endcase
  end

  assign cmd_valid = (state != ST_IDLE) && (state != ST_PUBLISH) &&
                     !eng_busy && !waiting;

  // One command in flight at a time
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      waiting <= 1'b0;
    end else if (eng_done) begin
      waiting <= 1'b0;
    end else if (cmd_valid) begin
      waiting <= 1'b1;
    end
  end

  // Fetch sequence; a refused byte aborts to a stop
  // (RULE_16) reset abandons transfer
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      abort <= 1'b0;
      idx <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          abort <= 1'b0;
          idx <= '0;
          // (RULE_15) low request starts fetch
          if (!req_s) begin
            state <= ST_START;
          end
        end
        ST_START: if (eng_done) state <= ST_ADDR_W;
        ST_RESTART: if (eng_done) state <= ST_ADDR_R;
        ST_ADDR_W, ST_REG, ST_ADDR_R: begin
          if (eng_done && eng_nack) begin
            abort <= 1'b1;
            state <= ST_STOP;
          end else if (eng_done) begin
            state <= (state == ST_ADDR_W) ? ST_REG :
                     (state == ST_REG) ? ST_RESTART : ST_READ;
          end
        end
        ST_READ: begin
          if (eng_done) begin
            idx <= idx + IW'(1);
            if (idx == LAST_IDX) state <= ST_STOP;
          end
        end
        ST_STOP: if (eng_done) state <= abort ? ST_IDLE : ST_PUBLISH;
        ST_PUBLISH: state <= ST_IDLE;
      endcase
    end
  end

  // Capture read bytes by index
  // (RULE_06) collect panel report
  always_ff @(posedge core_clk) begin
    if (state == ST_READ && eng_done) begin
      rx_buf[idx] <= eng_data;
    end
  end

  // Decode into result registers only when a read completes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      report <= '0;
    end else if (state == ST_PUBLISH) begin
      // (RULE_08) first point widths
      report.p1.x <= coord_x(rx_buf[touch_pkg::B_X1],
                             rx_buf[touch_pkg::B_X1 + 1]);
      report.p1.y <= coord_y(rx_buf[touch_pkg::B_Y1],
                             rx_buf[touch_pkg::B_Y1 + 1]);
      // (RULE_09) second point widths
      report.p2.x <= coord_x(rx_buf[touch_pkg::B_X2],
                             rx_buf[touch_pkg::B_X2 + 1]);
      report.p2.y <= coord_y(rx_buf[touch_pkg::B_Y2],
                             rx_buf[touch_pkg::B_Y2 + 1]);
      // (RULE_10) clamp count to two
      report.count <= (rx_buf[touch_pkg::B_COUNT] > 8'(touch_pkg::MAX_POINTS))
                      ? touch_pkg::MAX_POINTS
                      : rx_buf[touch_pkg::B_COUNT][touch_pkg::CNT_W-1:0];
      // (RULE_11) gesture code passes through
      // (RULE_12) (RULE_13) fixed codes kept unchanged
      report.gesture <= rx_buf[touch_pkg::B_GEST];
    end
  end

  // Ready drops when a fetch starts, rises with new results
  // (RULE_07) rise with valid data
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      result_valid_out <= 1'b0;
    end else if (state == ST_PUBLISH) begin
      result_valid_out <= 1'b1;
    end else if (state == ST_IDLE && !req_s) begin
      result_valid_out <= 1'b0;
    end
  end

  // (RULE_17) outputs only from report
  assign first_point_x = report.p1.x;
  assign first_point_y = report.p1.y;
  assign second_point_x = report.p2.x;
  assign second_point_y = report.p2.y;
  assign point_count = report.count;
  assign gesture_code = report.gesture;

  i2c_byte_engine #(.QUARTER(QUARTER)) u_engine (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .cmd_valid(cmd_valid),
    .cmd(cmd),
    .busy(eng_busy),
    .done(eng_done),
    .nack(eng_nack),
    .rd_data(eng_data),
    .scl(panel_serial_clk),
    .sda_oe(panel_serial_data_oe),
    .sda_out(panel_serial_data_out),
    .sda_in(panel_serial_data_in)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_reset_state: assert property (@(posedge core_clk) // RULE_16
    sys_rst |=> !result_valid_out && panel_serial_clk &&
                !panel_serial_data_oe && state == ST_IDLE)
    else $error("reset did not idle outputs");
  a_ready_cause: assert property ( // RULE_07
    $rose(result_valid_out) |-> $past(state) == ST_PUBLISH)
    else $error("ready rose without a completed read");
  a_results_hold: assert property ( // RULE_17
    (state != ST_PUBLISH) |=> $stable(report))
    else $error("results changed outside a publish");
  a_count_legal: assert property ( // RULE_10
    point_count <= touch_pkg::MAX_POINTS)
    else $error("point count out of range");
  a_fetch_start: assert property ( // RULE_15
    (state == ST_IDLE && !req_s) |=> state == ST_START && cmd_valid)
    else $error("low request did not start a fetch");
  a_gesture_decode: assert property ( // RULE_11
    (state == ST_PUBLISH) |=>
      gesture_code == $past(rx_buf[touch_pkg::B_GEST]))
    else $error("gesture code not taken from report");
  a_x_decode: assert property ( // RULE_08
    (state == ST_PUBLISH) |=>
      first_point_x[7:0] == $past(rx_buf[touch_pkg::B_X1 + 1]))
    else $error("first x low byte wrong");
  a_full_read: assert property ( // RULE_06
    (state == ST_STOP && eng_done && !abort) |->
      idx == IW'(touch_pkg::READ_BYTES))
    else $error("stop before all bytes were read");

  c_publish: cover property (state == ST_PUBLISH);
  c_abort: cover property (state == ST_STOP && abort);
  c_two_points: cover property ($rose(result_valid_out) ##0
                                point_count == touch_pkg::MAX_POINTS);
endmodule
`default_nettype wire

// ### rtl/touch_pkg.sv
// Purpose: Shared constants and types for the touch gesture reader.
// Assumes: 10 MHz core clock, standard-mode serial link to the panel.
// Notes: Byte layout of a panel report is fixed here; gesture codes are
//        listed for the host logic that classifies each report.
package touch_pkg;
  // Clock and link timing
  localparam int CLK_NS = 100;
  localparam int I2C_BIT_NS = 10000;
  // Quarter of a serial bit, rounded down, never below one cycle
  localparam int QUARTER_RAW = (I2C_BIT_NS / 4) / CLK_NS;
  localparam int QUARTER_CYC = (QUARTER_RAW < 1) ? 1 : QUARTER_RAW;

  // Result widths
  localparam int X_W = 10;
  localparam int Y_W = 9;
  localparam int CNT_W = 2;
  localparam int GEST_W = 8;
  localparam logic [1:0] MAX_POINTS = 2'h2;

  // Panel report layout: count, x1 hi/lo, y1 hi/lo, x2 hi/lo, y2 hi/lo, gesture
  localparam int READ_BYTES = 10;
  localparam int B_COUNT = 0;
  localparam int B_X1 = 1;
  localparam int B_Y1 = 3;
  localparam int B_X2 = 5;
  localparam int B_Y2 = 7;
  localparam int B_GEST = 9;

  // Bus framing bits
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;

  // One-point gestures (swipes step by two from north)
  localparam logic [7:0] G1_NORTH = 8'h10;
  localparam logic [7:0] G1_NORTH_WEST = 8'h1E;
  localparam logic [7:0] G1_CLICK = 8'h20;
  localparam logic [7:0] G1_DOUBLE_CLICK = 8'h22;
  localparam logic [7:0] G1_ROTATE_CW = 8'h28;
  localparam logic [7:0] G1_ROTATE_CCW = 8'h29;
  // Two-point gestures
  localparam logic [7:0] G2_NORTH = 8'h30;
  localparam logic [7:0] G2_NORTH_WEST = 8'h3E;
  localparam logic [7:0] G2_CLICK = 8'h40;
  localparam logic [7:0] G2_ZOOM_IN = 8'h48;
  localparam logic [7:0] G2_ZOOM_OUT = 8'h49;

  typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} i2c_op_t;

  // One byte-level command to the serial engine
  typedef struct packed {
    i2c_op_t op;
    logic [7:0] data;
    logic last;
  } i2c_cmd_t;

  typedef struct packed {
    logic [X_W-1:0] x;
    logic [Y_W-1:0] y;
  } touch_point_t;

  typedef struct packed {
    touch_point_t p1;
    touch_point_t p2;
    logic [CNT_W-1:0] count;
    logic [GEST_W-1:0] gesture;
  } touch_report_t;
endpackage

// ### rtl/i2c_byte_engine.sv
// Purpose: Serial master engine, one start, stop or byte per command.
// Assumes: Each bit takes four quarter phases of QUARTER cycles.
// Notes: Data line is open drain; clock line is driven push-pull.
`timescale 1ns/1ps
`default_nettype none
module i2c_byte_engine #(
  parameter int QUARTER = touch_pkg::QUARTER_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire touch_pkg::i2c_cmd_t cmd,
  output logic busy,
  output logic done,
  output logic nack,
  output logic [7:0] rd_data,
  output logic scl,
  output logic sda_oe,
  output logic sda_out,
  input wire logic sda_in
);
  localparam int QW = $clog2(QUARTER + 1);
  touch_pkg::i2c_op_t op;
  logic [8:0] tx;
  logic [8:0] rx;
  logic [3:0] bit_idx;
  logic [1:0] phase;
  logic [QW-1:0] qcnt;
  logic sda_m;
  logic sda_s;
  logic next_scl;
  logic next_sda_hi;
  logic phase_end;
  logic is_bit;

  assign phase_end = busy && (qcnt == QW'(QUARTER - 1));
  assign is_bit = (op == touch_pkg::OP_WRITE) || (op == touch_pkg::OP_READ);

  // Two-stage synchroniser on the data pin
  always_ff @(posedge core_clk) begin
    sda_m <= sda_in;
    sda_s <= sda_m;
  end

  // Line levels for the current phase; lines hold while idle
  always_comb begin
    next_scl = scl;
    next_sda_hi = !sda_oe;
    if (busy) begin
      unique case (op)
        touch_pkg::OP_START: begin
          next_scl = (phase == 2'h1) || (phase == 2'h2);
          next_sda_hi = (phase < 2'h2);
        end
        touch_pkg::OP_STOP: begin
          next_scl = (phase != 2'h0);
          next_sda_hi = (phase >= 2'h2);
        end
        touch_pkg::OP_WRITE, touch_pkg::OP_READ: begin
          next_scl = (phase == 2'h1) || (phase == 2'h2);
          next_sda_hi = tx[8];
        end
      endcase
    end
  end

  // Pin registers; reset drives the clock high and releases the data line
  // (RULE_04) master drives clock
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      scl <= 1'b1;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      scl <= next_scl;
      // (RULE_05) release for reading
      sda_oe <= !next_sda_hi;
      sda_out <= 1'b0;
    end
  end

  // Command sequencing through phases and bits
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      nack <= 1'b0;
      rd_data <= 8'h00;
      op <= touch_pkg::OP_STOP;
      tx <= 9'h1FF;
      rx <= 9'h000;
      bit_idx <= 4'h0;
      phase <= 2'h0;
      qcnt <= '0;
    end else begin
      done <= 1'b0;
      if (!busy) begin
        if (cmd_valid) begin
          busy <= 1'b1;
          op <= cmd.op;
          phase <= 2'h0;
          qcnt <= '0;
          bit_idx <= 4'h0;
          // Read releases data bits, then acks unless last
          tx <= (cmd.op == touch_pkg::OP_READ) ?
                {touch_pkg::IDLE_BYTE, cmd.last} : {cmd.data, 1'b1};
        end
      end else if (!phase_end) begin
        qcnt <= qcnt + QW'(1);
      end else begin
        qcnt <= '0;
        phase <= phase + 2'h1;
        if (is_bit && phase == 2'h1) begin
          rx <= {rx[7:0], sda_s};
        end
        if (phase == 2'h3) begin
          if (is_bit && bit_idx < 4'h8) begin
            bit_idx <= bit_idx + 4'h1;
            tx <= {tx[7:0], 1'b1};
          end else begin
            busy <= 1'b0;
            done <= 1'b1;
            rd_data <= rx[8:1];
            nack <= rx[0];
          end
        end
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_cmd_completes: assert property ( // RULE_04
    (!busy && cmd_valid) |-> ##[1:1000] done)
    else $error("engine command did not complete");
  a_read_released: assert property ( // RULE_05
    (busy && op == touch_pkg::OP_READ && bit_idx < 4'h8) |=> !sda_oe)
    else $error("data line driven during read bits");
  a_sda_scl_low: assert property ( // RULE_05
    (busy && is_bit && $changed(sda_oe)) |-> !scl)
    else $error("data changed while clock high");
endmodule
`default_nettype wire

// ### verif/panel_model.sv
// Purpose: Behavioural panel controller that answers the serial reads.
// Assumes: Data line has a pull-up; the master drives the clock.
// Notes: Data changes only while the clock is low; no clock stretching.
`timescale 1ns/1ps
`default_nettype none
module panel_model #(
  parameter logic [6:0] ADDR = 7'h38
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic refuse,
  input wire logic [79:0] report,
  output logic sda_pull,
  output logic [7:0] first_byte
);
  int bitn;
  int idx;
  logic [7:0] sh;
  logic [7:0] cur;
  logic first;
  logic active;
  logic reading;
  logic rd_done;
  initial begin
    sda_pull = 1'b0;
    first_byte = 8'h00;
    active = 1'b0;
    bitn = 0;
  end
  // Start or repeated start restarts byte framing
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      active = 1'b1;
      bitn = 0;
      idx = 0;
      first = 1'b1;
      reading = 1'b0;
      rd_done = 1'b0;
    end
  end
  // Stop ends the transfer and frees the line
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      active = 1'b0;
      sda_pull = 1'b0;
    end
  end
  // Sample data bits and the master acknowledge
  always @(posedge scl) begin
    if (active) begin
      if (bitn < 8) sh = {sh[6:0], sda};
      else if (reading && sda) rd_done = 1'b1;
      bitn = bitn + 1;
    end
  end
  always @(negedge scl) begin
    if (active) begin
      if (bitn == 8) begin
        if (reading) sda_pull = 1'b0;
        else if (first) begin
          first_byte = sh;
          first = 1'b0;
          reading = sh[0];
          sda_pull = !refuse && (sh[7:1] == ADDR);
        end else sda_pull = 1'b1;
      end else if (bitn == 9) begin
        bitn = 0;
        if (reading && !rd_done) begin
          cur = report[79 - 8 * idx -: 8];
          idx = idx + 1;
          sda_pull = !cur[7];
        end else sda_pull = 1'b0;
      end else if (reading && !rd_done && bitn > 0) begin
        sda_pull = !cur[7 - bitn];
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/touch_gesture_reader_test.sv
// Purpose: Self-checking bench for the touch gesture reader.
// Assumes: Short quarter phase so one serial bit lasts 800 ns.
// Notes: Mid-fetch reset runs last, as it may leave the panel stuck.
`timescale 1ns/1ps
`default_nettype none
module touch_gesture_reader_test;
  localparam int Q = 2;
  localparam logic [6:0] ADDR = 7'h38;
  logic core_clk = 1'b0;
  logic sys_rst;
  logic touch_request_in;
  logic refuse;
  logic result_valid_out;
  logic [touch_pkg::X_W-1:0] x1;
  logic [touch_pkg::Y_W-1:0] y1;
  logic [touch_pkg::X_W-1:0] x2;
  logic [touch_pkg::Y_W-1:0] y2;
  logic [touch_pkg::CNT_W-1:0] cnt;
  logic [touch_pkg::GEST_W-1:0] gest;
  logic scl;
  logic data_out;
  logic data_oe;
  logic pull;
  logic [79:0] report;
  logic [7:0] first_byte;
  wire logic sda_line;
  touch_pkg::touch_report_t seen;
  touch_pkg::touch_report_t last_exp;
  int fails = 0;
  int checks = 0;
  int cycles = 0;

  // Open-drain data line with pull-up
  assign sda_line = !(data_oe || pull);
  assign seen = {x1, y1, x2, y2, cnt, gest};

  touch_gesture_reader #(.PANEL_ADDR(ADDR), .QUARTER(Q))
    touch_gesture_reader_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .touch_request_in(touch_request_in), .result_valid_out(result_valid_out),
    .first_point_x(x1), .first_point_y(y1), .second_point_x(x2),
    .second_point_y(y2), .point_count(cnt), .gesture_code(gest),
    .panel_serial_clk(scl), .panel_serial_data_out(data_out),
    .panel_serial_data_oe(data_oe), .panel_serial_data_in(sda_line));

  panel_model #(.ADDR(ADDR)) panel_model_i (.scl(scl), .sda(sda_line),
    .refuse(refuse), .report(report), .sda_pull(pull),
    .first_byte(first_byte));

  // Clock and hang guard
  // single reference clock
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fails++;
      tally_and_finish;
    end
  end

  task automatic tally_and_finish;
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk_rep(input string n, input touch_pkg::touch_report_t e,
      input touch_pkg::touch_report_t g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // Report bytes with junk in unused high bits
  function automatic logic [79:0] build(input touch_pkg::touch_report_t r,
      input logic [7:0] raw);
    return {raw, 6'h2a, r.p1.x, 7'h55, r.p1.y, 6'h15, r.p2.x, 7'h2a,
      r.p2.y, r.gesture};
  endfunction

  // One full fetch; checks the ready drop and the published result
  task automatic fetch(input touch_pkg::touch_report_t r,
      input logic [7:0] raw);
    logic ok;
    ok = 1'b0;
    r.count = (raw > 8'h02) ? touch_pkg::MAX_POINTS : raw[1:0];
    report = build(r, raw);
    @(posedge core_clk);
    touch_request_in <= 1'b0;
    repeat (40) begin
      @(negedge core_clk);
      if (scl === 1'b0) ok = 1'b1;
      if (ok) break;
    end
    @(posedge core_clk);
    touch_request_in <= 1'b1;
    chk_bit("ready low in fetch", 1'b0, result_valid_out);
    if (ok) begin
      ok = 1'b0;
      repeat (3000) begin
        @(negedge core_clk);
        if (result_valid_out === 1'b1) ok = 1'b1;
        if (ok) break;
      end
    end
    chk_bit("ready rose", 1'b1, ok);
    chk_rep("report", r, seen);
    chk_bit("read address", 1'b1, first_byte === {ADDR, 1'b1});
    last_exp = r;
  endtask

  task automatic t_reset;
    @(negedge core_clk);
    chk_bit("ready after reset", 1'b0, result_valid_out);
    chk_bit("clock idle", 1'b1, scl);
    chk_bit("data released", 1'b0, data_oe);
    chk_bit("data out low", 1'b0, data_out);
    chk_rep("reset results", '0, seen);
  endtask

  task automatic t_basic;
    logic ok;
    fetch('{'{10'h3ff, 9'h1ff}, '{10'h001, 9'h100}, 2'h0,
      touch_pkg::G2_ZOOM_IN}, 8'h02);
    ok = 1'b1;
    repeat (100) begin
      @(negedge core_clk);
      if (result_valid_out !== 1'b1 || seen !== last_exp) ok = 1'b0;
    end
    chk_bit("results held", 1'b1, ok);
  endtask

  task automatic t_gestures;
    logic [7:0] codes [22] = '{8'h10, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1a,
      8'h1c, 8'h1e, 8'h20, 8'h22, 8'h28, 8'h29, 8'h30, 8'h32, 8'h34,
      8'h36, 8'h38, 8'h3a, 8'h3c, 8'h3e, 8'h40, 8'h49};
    logic [7:0] raws [4] = '{8'h00, 8'h01, 8'h02, 8'h07};
    for (int i = 0; i < 23; i++) begin
      fetch('{'{10'(i * 37), 9'(i * 21)}, '{10'(1000 - i), 9'(i * 5)},
        2'h0, (i < 22) ? codes[i] : 8'h77}, raws[i % 4]);
    end
  endtask

  task automatic t_refuse;
    logic ok;
    ok = 1'b1;
    refuse = 1'b1;
    @(posedge core_clk);
    touch_request_in <= 1'b0;
    repeat (10) @(posedge core_clk);
    touch_request_in <= 1'b1;
    repeat (600) begin
      @(negedge core_clk);
      if (result_valid_out !== 1'b0) ok = 1'b0;
    end
    chk_bit("no publish on refusal", 1'b1, ok);
    chk_rep("old results kept", last_exp, seen);
    chk_bit("clock idle after abort", 1'b1, scl);
    chk_bit("data idle after abort", 1'b0, data_oe);
    refuse = 1'b0;
  endtask

  task automatic t_midreset;
    @(posedge core_clk);
    touch_request_in <= 1'b0;
    repeat (200) @(posedge core_clk);
    sys_rst <= 1'b1;
    touch_request_in <= 1'b1;
    @(posedge core_clk);
    t_reset;
    @(posedge core_clk);
    sys_rst <= 1'b0;
  endtask

  initial begin
    sys_rst = 1'b1;
    touch_request_in = 1'b1;
    refuse = 1'b0;
    report = '0;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset;
    t_basic;
    t_gestures;
    t_refuse;
    t_midreset;
    tally_and_finish;
  end
endmodule
`default_nettype wire
